//--- verilog/epc_cfg.svh
// Offsets, field positions, reset values for the programming control block
`ifndef EPC_CFG_SVH
`define EPC_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define EPC_OFF_CTRL       12'h000
`define EPC_OFF_PROG_ADDR  12'h004
`define EPC_OFF_PROG_DATA  12'h008
`define EPC_OFF_STATUS     12'h00c

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define EPC_BIT_PGM        0
`define EPC_BIT_T0         1
`define EPC_BIT_T1         2
`define EPC_BIT_EXTRA_ROWS_SELECT      3
`define EPC_BIT_EXTRA_COLUMNS_SELECT      4
`define EPC_BIT_PROGRAM_LATCH_SELECT       5
`define EPC_BIT_UNUSED6    6
`define EPC_BIT_MBE        7
`define EPC_CTRL_RESET     8'h00

// ----------------------------------------------------------------
// Test mode encodings
// ----------------------------------------------------------------
`define EPC_TEST_NORMAL    2'h0
`define EPC_TEST_RESERVED  2'h1
`define EPC_TEST_GATE      2'h2
`define EPC_TEST_DRAIN     2'h3

// ----------------------------------------------------------------
// Address fields
// ----------------------------------------------------------------
`define EPC_ADDR_PAIR_BIT  5
`define EPC_EXTRA_COLUMNS_SELECT_LOW_W    5
`define EPC_EXTRA_ROWS_SELECT_LOW_W    8

`endif

//--- verilog/epc_pkg.sv
// Types shared by the programming control block
package epc_pkg;

    // Which array the address bus currently reaches
    typedef enum logic [1:0] {
        EPC_SEL_USER,
        EPC_SEL_EXTRA_COLUMNS_SELECT,
        EPC_SEL_EXTRA_ROWS_SELECT
    } epc_sel_e;

    // Two-bit stress test field
    typedef logic [1:0] epc_tmode_t;

endpackage

//--- verilog/epc_addr_map.sv
// Array address folding for extra columns, extra rows and paired bytes
`timescale 1ns/1ns
`default_nettype none
`include "epc_cfg.svh"

module epc_addr_map
    import epc_pkg::*;
#(
    parameter int ADDR_W = 14
) (
    input  wire logic [ADDR_W-1:0] addrIn,     // Address from the CPU side
    input  wire epc_pkg::epc_sel_e arraySel,   // Active array selection
    input  wire logic              pairMode,   // Fold the pair bit away
    output logic      [ADDR_W-1:0] addrOut     // Address seen by the array
);

    // ------------------------------------------------------------
    // Folding
    // ------------------------------------------------------------
    // Don't-care bits are forced low so the array sees one code
    always_comb begin
        addrOut = addrIn;
        unique case (arraySel)
            EPC_SEL_USER: begin
                addrOut = addrIn;
            end
            EPC_SEL_EXTRA_COLUMNS_SELECT: begin
                addrOut[`EPC_EXTRA_COLUMNS_SELECT_LOW_W-1:0] = '0;
            end
            EPC_SEL_EXTRA_ROWS_SELECT: begin
                addrOut[ADDR_W-1:`EPC_EXTRA_ROWS_SELECT_LOW_W] = '0;
            end
            default: begin
                addrOut = addrIn;
            end
        endcase
        // Both halves of the pair share one programmed byte
        if (pairMode) begin
            addrOut[`EPC_ADDR_PAIR_BIT] = 1'b0;
        end
    end

endmodule
`default_nettype wire

//--- verilog/epc_eprom_program_control.sv
// Programming control for the one-time-programmable array, APB slave
//
// The register offsets and register access over APB were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "epc_cfg.svh"

module epc_eprom_program_control
    import epc_pkg::*;
#(
    parameter int APB_AW = 12,                 // APB address width
    parameter int ADDR_W = 14,                 // Array address width
    parameter int DATA_W = 8                   // Array data width
) (
    input  wire logic              sys_clk,        // System clock
    input  wire logic              resetn,         // Async reset, low
    // APB slave
    input  wire logic              psel,           // Slave select
    input  wire logic              penable,        // Access phase
    input  wire logic              pwrite,         // Write direction
    input  wire logic [APB_AW-1:0] paddr,          // Byte address
    input  wire logic [31:0]       pwdata,         // Write data
    input  wire logic [3:0]        pstrb,          // Byte strobes
    output logic      [31:0]       prdata,         // Read data
    output logic                   pready,         // Transfer done
    output logic                   pslverr,        // Unmapped address
    // Operating mode pin
    input  wire logic              specialModeIn,  // High in special modes
    // CPU side of the array bus
    input  wire logic              arrReq,         // Array access strobe
    input  wire logic              arrWe,          // Access is a write
    input  wire logic [ADDR_W-1:0] arrAddr,        // Array address
    input  wire logic [DATA_W-1:0] arrWdata,       // Array write data
    // Array side
    output logic                   memRdEn,        // Normal read strobe
    output logic      [ADDR_W-1:0] memAddr,        // Folded read address
    output epc_pkg::epc_sel_e      memSel,         // Array selection
    output logic                   readBlocked,    // Read refused pulse
    output logic      [ADDR_W-1:0] progAddr,       // Latched address
    output logic      [DATA_W-1:0] progData,       // Latched data
    output logic                   progLatchValid, // Latch holds a byte
    output logic                   progPair,       // Program both bytes
    output logic                   progVoltageOn,  // Program pulse level
    output epc_pkg::epc_tmode_t    testMode,       // Effective test mode
    output logic                   gateStress,     // Gate stress active
    output logic                   drainStress     // Drain stress active
);
    import epc_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic              modeMeta;          // Synchroniser first stage
    logic              specialMode;       // Synchronised mode level
    logic [7:0]        ctrl;              // Stored control bits
    logic [7:0]        next_ctrl;         // Next control bits
    logic [7:0]        ctrlView;          // Control as software reads it
    logic [31:0]       next_prdata;       // Next read data
    logic              next_pready;       // Next ready
    logic              next_pslverr;      // Next error
    logic              apbDone;           // Transfer completes now
    logic              ctrlWr;            // Control write this edge
    logic              addrHit;           // Address is mapped
    logic              multiByte;         // Effective pair mode
    logic              latchOn;           // Latch mode active
    epc_sel_e          arraySel;          // Effective selection
    epc_tmode_t        effTest;           // Effective test field
    logic [ADDR_W-1:0] mappedAddr;        // Folded address
    logic              next_memRdEn;      // Next read strobe
    logic [ADDR_W-1:0] next_memAddr;      // Next read address
    epc_sel_e          next_memSel;       // Next selection
    logic              next_readBlocked;  // Next refusal pulse
    logic [ADDR_W-1:0] next_progAddr;     // Next latched address
    logic [DATA_W-1:0] next_progData;     // Next latched data
    logic              next_progValid;    // Next latch valid
    logic              next_progPair;     // Next pair flag
    logic              next_voltage;      // Next voltage level
    epc_tmode_t        next_testMode;     // Next test output
    logic              next_gate;         // Next gate stress
    logic              next_drain;        // Next drain stress

    // ------------------------------------------------------------
    // Mode synchroniser
    // ------------------------------------------------------------
    // The mode level comes from a pin, so it is retimed first
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            modeMeta    <= 1'b0;
            specialMode <= 1'b0;
        end else begin
            modeMeta    <= specialModeIn;
            specialMode <= modeMeta;
        end
    end

    // ------------------------------------------------------------
    // Effective control view
    // ------------------------------------------------------------
    // Restricted bits keep their stored value but act and read as
    // zero outside special modes; returning to special mode brings
    // them back, which saves a clear path on every mode change.
    always_comb begin
        ctrlView                  = 8'h00;
        ctrlView[`EPC_BIT_PGM]    = ctrl[`EPC_BIT_PGM];
        ctrlView[`EPC_BIT_PROGRAM_LATCH_SELECT]   = ctrl[`EPC_BIT_PROGRAM_LATCH_SELECT];
        if (specialMode) begin
            ctrlView[`EPC_BIT_MBE]   = ctrl[`EPC_BIT_MBE];
            ctrlView[`EPC_BIT_EXTRA_COLUMNS_SELECT] = ctrl[`EPC_BIT_EXTRA_COLUMNS_SELECT];
            ctrlView[`EPC_BIT_EXTRA_ROWS_SELECT] = ctrl[`EPC_BIT_EXTRA_ROWS_SELECT];
            ctrlView[`EPC_BIT_T1]    = ctrl[`EPC_BIT_T1];
            ctrlView[`EPC_BIT_T0]    = ctrl[`EPC_BIT_T0];
        end
    end

    // Functional decode of the effective view
    always_comb begin
        multiByte = ctrlView[`EPC_BIT_MBE];
        latchOn   = ctrlView[`EPC_BIT_PROGRAM_LATCH_SELECT];
        effTest   = {ctrlView[`EPC_BIT_T1], ctrlView[`EPC_BIT_T0]};
        // Extra columns win if both selects are set
        if (ctrlView[`EPC_BIT_EXTRA_COLUMNS_SELECT]) begin
            arraySel = EPC_SEL_EXTRA_COLUMNS_SELECT;
        end else if (ctrlView[`EPC_BIT_EXTRA_ROWS_SELECT]) begin
            arraySel = EPC_SEL_EXTRA_ROWS_SELECT;
        end else begin
            arraySel = EPC_SEL_USER;
        end
    end

    // ------------------------------------------------------------
    // APB slave
    // ------------------------------------------------------------
    // One wait state so read data and ready come from flops
    always_comb begin
        apbDone = psel && penable && pready;
        ctrlWr  = apbDone && pwrite && pstrb[0]
                  && (paddr == `EPC_OFF_CTRL);
        unique case (paddr)
            `EPC_OFF_CTRL,
            `EPC_OFF_PROG_ADDR,
            `EPC_OFF_PROG_DATA,
            `EPC_OFF_STATUS: begin
                addrHit = 1'b1;
            end
            default: begin
                addrHit = 1'b0;
            end
        endcase
    end

    // Ready rises in the second access cycle, then drops again
    always_comb begin
        next_pready  = psel && penable && !pready;
        next_pslverr = psel && penable && !pready && !addrHit;
        next_prdata  = 32'h0000_0000;
        if (psel && penable && !pready && !pwrite) begin
            unique case (paddr)
                `EPC_OFF_CTRL: begin
                    next_prdata[7:0] = ctrlView;
                end
                `EPC_OFF_PROG_ADDR: begin
                    next_prdata[ADDR_W-1:0] = progAddr;
                end
                `EPC_OFF_PROG_DATA: begin
                    next_prdata[DATA_W-1:0] = progData;
                end
                `EPC_OFF_STATUS: begin
                    next_prdata[0] = progLatchValid;
                    next_prdata[1] = specialMode;
                    next_prdata[2] = progPair;
                    next_prdata[4:3] = {1'b0, memSel == EPC_SEL_EXTRA_COLUMNS_SELECT}
                                     | {memSel == EPC_SEL_EXTRA_ROWS_SELECT, 1'b0};
                end
                default: begin
                    next_prdata = 32'h0000_0000;
                end
            endcase
        end
    end

    // APB output registers
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= next_pready;
            pslverr <= next_pslverr;
            prdata  <= next_prdata;
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    // Each field follows its own write permission
    always_comb begin
        next_ctrl = ctrl;
        if (ctrlWr) begin
            next_ctrl[`EPC_BIT_PGM] = pwdata[`EPC_BIT_PGM];
            // Latch mode is frozen while the program voltage is on
            if (!ctrl[`EPC_BIT_PGM]) begin
                next_ctrl[`EPC_BIT_PROGRAM_LATCH_SELECT] = pwdata[`EPC_BIT_PROGRAM_LATCH_SELECT];
            end
            if (specialMode) begin
                next_ctrl[`EPC_BIT_MBE]   = pwdata[`EPC_BIT_MBE];
                next_ctrl[`EPC_BIT_EXTRA_COLUMNS_SELECT] = pwdata[`EPC_BIT_EXTRA_COLUMNS_SELECT];
                next_ctrl[`EPC_BIT_EXTRA_ROWS_SELECT] = pwdata[`EPC_BIT_EXTRA_ROWS_SELECT];
                next_ctrl[`EPC_BIT_T1]    = pwdata[`EPC_BIT_T1];
                next_ctrl[`EPC_BIT_T0]    = pwdata[`EPC_BIT_T0];
            end
        end
        next_ctrl[`EPC_BIT_UNUSED6] = 1'b0;
    end

    // Control register storage
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl <= `EPC_CTRL_RESET;
        end else begin
            ctrl <= next_ctrl;
        end
    end

    // ------------------------------------------------------------
    // Address folding
    // ------------------------------------------------------------
    epc_addr_map #(
        .ADDR_W   (ADDR_W)
    ) uAddrMap (
        .addrIn   (arrAddr),
        .arraySel (arraySel),
        .pairMode (multiByte && latchOn),
        .addrOut  (mappedAddr)
    );

    // ------------------------------------------------------------
    // Array access path
    // ------------------------------------------------------------
    // Latch mode turns writes into captures and refuses reads
    always_comb begin
        next_memRdEn     = 1'b0;
        next_memAddr     = memAddr;
        next_memSel      = arraySel;
        next_readBlocked = 1'b0;
        next_progAddr    = progAddr;
        next_progData    = progData;
        next_progValid   = progLatchValid && latchOn;
        next_progPair    = multiByte && latchOn;
        if (arrReq) begin
            if (latchOn) begin
                if (arrWe) begin
                    next_progAddr  = mappedAddr;
                    next_progData  = arrWdata;
                    next_progValid = 1'b1;
                end else begin
                    next_readBlocked = 1'b1;
                end
            end else if (!arrWe) begin
                next_memRdEn = 1'b1;
                next_memAddr = mappedAddr;
            end
        end
    end

    // Array path registers
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            memRdEn        <= 1'b0;
            memAddr        <= '0;
            memSel         <= EPC_SEL_USER;
            readBlocked    <= 1'b0;
            progAddr       <= '0;
            progData       <= '0;
            progLatchValid <= 1'b0;
            progPair       <= 1'b0;
        end else begin
            memRdEn        <= next_memRdEn;
            memAddr        <= next_memAddr;
            memSel         <= next_memSel;
            readBlocked    <= next_readBlocked;
            progAddr       <= next_progAddr;
            progData       <= next_progData;
            progLatchValid <= next_progValid;
            progPair       <= next_progPair;
        end
    end

    // ------------------------------------------------------------
    // Program pulse and stress modes
    // ------------------------------------------------------------
    // The reserved code selects no stress, like normal operation
    always_comb begin
        next_voltage  = ctrl[`EPC_BIT_PGM];
        next_testMode = effTest;
        next_gate     = 1'b0;
        next_drain    = 1'b0;
        unique case (effTest)
            `EPC_TEST_NORMAL: begin
                next_gate = 1'b0;
            end
            `EPC_TEST_RESERVED: begin
                next_gate = 1'b0;
            end
            `EPC_TEST_GATE: begin
                next_gate = 1'b1;
            end
            `EPC_TEST_DRAIN: begin
                next_drain = 1'b1;
            end
        endcase
    end

    // Pulse and stress registers
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            progVoltageOn <= 1'b0;
            testMode      <= `EPC_TEST_NORMAL;
            gateStress    <= 1'b0;
            drainStress   <= 1'b0;
        end else begin
            progVoltageOn <= next_voltage;
            testMode      <= next_testMode;
            gateStress    <= next_gate;
            drainStress   <= next_drain;
        end
    end

endmodule
`default_nettype wire

//--- bench/epc_ctrl_asserts.sv
// Port-level checker for the programming control block
`timescale 1ns/1ns
`default_nettype none
`include "epc_cfg.svh"
module epc_ctrl_asserts
    import epc_pkg::*;
#(
    parameter int APB_AW = 12,
    parameter int ADDR_W = 14,
    parameter int DATA_W = 8
) (
    input wire logic              sys_clk,
    input wire logic              resetn,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0]       pwdata,
    input wire logic [3:0]        pstrb,
    input wire logic [31:0]       prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic              specialModeIn,
    input wire logic              arrReq,
    input wire logic              arrWe,
    input wire logic [ADDR_W-1:0] arrAddr,
    input wire logic [DATA_W-1:0] arrWdata,
    input wire logic              memRdEn,
    input wire logic [ADDR_W-1:0] memAddr,
    input wire epc_sel_e          memSel,
    input wire logic              readBlocked,
    input wire logic [ADDR_W-1:0] progAddr,
    input wire logic [DATA_W-1:0] progData,
    input wire logic              progLatchValid,
    input wire logic              progPair,
    input wire logic              progVoltageOn,
    input wire epc_tmode_t        testMode,
    input wire logic              gateStress,
    input wire logic              drainStress
);
    // ----------------------------------------------------------------
    // One clock domain, so one clocking and one disable
    // ----------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);

    // Paired writes land on the even byte of the pair
    property p_pair;
        arrReq && arrWe && progPair |=> progAddr[5] == 1'b0;
    endproperty
    a_pair: assert property (p_pair) else $error("pair bit kept");
    // Mode lag is a few flops, so normal mode must hold a while first
    property p_nrmRead;
        !specialModeIn [*5] ##0 (pready && !pwrite && paddr == `EPC_OFF_CTRL)
            |-> prdata[7:6] == 2'h0 && prdata[4:1] == 4'h0;
    endproperty
    a_nrmRead: assert property (p_nrmRead) else $error("restricted bits read");
    // A refused read never also strobes the array
    property p_blk;
        readBlocked |-> !memRdEn && $past(arrReq && !arrWe);
    endproperty
    a_blk: assert property (p_blk) else $error("bad read refusal");
    property p_rdEn;
        memRdEn |-> $past(arrReq && !arrWe);
    endproperty
    a_rdEn: assert property (p_rdEn) else $error("read strobe uncaused");
    // Latched byte only moves when the CPU side asks
    property p_hold;
        !$past(arrReq) && $past(progLatchValid) && progLatchValid
            |-> $stable(progAddr) && $stable(progData);
    endproperty
    a_hold: assert property (p_hold) else $error("latched byte moved");
    property p_extra_columns_select;
        memRdEn && memSel == EPC_SEL_EXTRA_COLUMNS_SELECT |-> memAddr[4:0] == 5'h00;
    endproperty
    a_extra_columns_select: assert property (p_extra_columns_select) else $error("column low bits kept");
    property p_extra_rows_select;
        memRdEn && memSel == EPC_SEL_EXTRA_ROWS_SELECT |-> memAddr[13:8] == 6'h00;
    endproperty
    a_extra_rows_select: assert property (p_extra_rows_select) else $error("row high bits kept");
    property p_stress;
        gateStress == (testMode == 2'h2) && drainStress == (testMode == 2'h3);
    endproperty
    a_stress: assert property (p_stress) else $error("stress decode wrong");
    property p_nrmMode;
        !specialModeIn [*5] |-> testMode == 2'h0 && memSel == EPC_SEL_USER && !progPair;
    endproperty
    a_nrmMode: assert property (p_nrmMode) else $error("normal mode leak");

    // ----------------------------------------------------------------
    // Coverage of the main scenarios
    // ----------------------------------------------------------------
    c_blk: cover property (readBlocked);
    c_pair: cover property (progPair && progLatchValid);
    c_drain: cover property (drainStress);
endmodule
bind epc_eprom_program_control epc_ctrl_asserts #(
    .APB_AW(APB_AW),
    .ADDR_W(ADDR_W),
    .DATA_W(DATA_W)
) i_epc_ctrl_asserts (.*);
`default_nettype wire

//--- bench/test_eprom_program_control.sv
// Self-checking bench for the programming control block
`timescale 1ns/1ns
`default_nettype none
`include "epc_cfg.svh"
module test_eprom_program_control;
    import epc_pkg::*;
    // ----------------------------------------------------------------
    // Stimulus, all given a value at time zero
    // ----------------------------------------------------------------
    logic        sys_clk = 1'b0;        // 100 MHz clock
    logic        resetn = 1'b0;         // Held low at start
    logic        psel = 1'b0;           // APB select
    logic        penable = 1'b0;        // APB access phase
    logic        pwrite = 1'b0;         // APB direction
    logic [11:0] paddr = 12'h000;       // APB byte address
    logic [31:0] pwdata = 32'h0;        // APB write data
    logic [3:0]  pstrb = 4'hf;          // Whole word written
    logic        specialModeIn = 1'b0;  // Start in normal mode
    logic        arrReq = 1'b0;         // Array access strobe
    logic        arrWe = 1'b0;          // Array write
    logic [13:0] arrAddr = 14'h0;       // Array address
    logic [7:0]  arrWdata = 8'h0;       // Array write data
    // Observed outputs
    logic [31:0] prdata;
    logic        pready, pslverr, memRdEn, readBlocked, progLatchValid;
    logic        progPair, progVoltageOn, gateStress, drainStress;
    logic [13:0] memAddr, progAddr;
    logic [7:0]  progData;
    epc_sel_e    memSel;
    epc_tmode_t  testMode;
    int          errTotal = 0;          // Mismatches
    int          cmpCount = 0;          // Comparisons

    epc_eprom_program_control i_epc_eprom_program_control (.*);

    always #5 sys_clk = ~sys_clk;

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmpCount++;
        if (got !== exp) begin
            errTotal++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // Request held until pready is seen high at a rising edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge sys_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Each pass looks at pready as it stood at this rising edge
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) errTotal++;
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, `EPC_OFF_CTRL, {24'h0, d}, r, e);
    endtask
    task automatic rdc(input string what, input logic [11:0] a, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, a, 32'h0, r, e);
        chk(what, exp, r);
    endtask
    // Outputs are looked at in the cycle after the strobe is taken
    task automatic arr(input logic we, input logic [13:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        arrReq <= 1'b1;
        arrWe <= we;
        arrAddr <= a;
        arrWdata <= d;
        @(posedge sys_clk);
        arrReq <= 1'b0;
        #1;
    endtask
    // Mode pin passes through synchronisers, so let it settle
    task automatic mode(input logic m);
        @(posedge sys_clk);
        specialModeIn <= m;
        repeat (6) @(posedge sys_clk);
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic tModes();
        rdc("ctrl", `EPC_OFF_CTRL, 32'h0);
        wr(8'hfe);
        rdc("ctrl", `EPC_OFF_CTRL, 32'h20);
        mode(1'b1);
        wr(8'hde);
        rdc("ctrl", `EPC_OFF_CTRL, 32'h9e);
        mode(1'b0);
        rdc("ctrl", `EPC_OFF_CTRL, 32'h0);
        chk("testMode", 32'h0, testMode);
        mode(1'b1);
        rdc("ctrl", `EPC_OFF_CTRL, 32'h9e);
    endtask
    task automatic tStress();
        for (int c = 0; c < 4; c++) begin
            wr(8'(c << 1));
            repeat (3) @(posedge sys_clk);
            chk("testMode", 32'(c), testMode);
            chk("gate", 32'(c == 2), gateStress);
            chk("drain", 32'(c == 3), drainStress);
        end
    endtask
    // A latch write in the same write that clears the voltage is lost
    task automatic tVoltage();
        wr(8'h01);
        wr(8'h21);
        rdc("ctrl", `EPC_OFF_CTRL, 32'h01);
        chk("voltage", 32'h1, progVoltageOn);
        wr(8'h20);
        rdc("ctrl", `EPC_OFF_CTRL, 32'h00);
        wr(8'h20);
        rdc("ctrl", `EPC_OFF_CTRL, 32'h20);
    endtask
    task automatic tLatch();
        arr(1'b0, 14'h1234, 8'h00);
        chk("blocked", 32'h1, readBlocked);
        chk("rdEn", 32'h0, memRdEn);
        arr(1'b1, 14'h3fff, 8'ha5);
        chk("progAddr", 32'h3fff, progAddr);
        chk("progData", 32'ha5, progData);
        wr(8'ha0);
        arr(1'b1, 14'h3fff, 8'h5a);
        chk("progAddr", 32'h3fdf, progAddr);
        chk("progPair", 32'h1, progPair);
        rdc("status", `EPC_OFF_STATUS, 32'h07);
        rdc("progAddrReg", `EPC_OFF_PROG_ADDR, 32'h3fdf);
        rdc("progDataReg", `EPC_OFF_PROG_DATA, 32'h5a);
        wr(8'h00);
        arr(1'b1, 14'h0555, 8'h11);
        chk("latchValid", 32'h0, progLatchValid);
    endtask
    task automatic tFold();
        arr(1'b0, 14'h1234, 8'h00);
        chk("rdEn", 32'h1, memRdEn);
        chk("memAddr", 32'h1234, memAddr);
        wr(8'h10);
        arr(1'b0, 14'h3fff, 8'h00);
        chk("memAddr", 32'h3fe0, memAddr);
        chk("memSel", 32'(EPC_SEL_EXTRA_COLUMNS_SELECT), memSel);
        wr(8'h08);
        arr(1'b0, 14'h3fff, 8'h00);
        chk("memAddr", 32'h00ff, memAddr);
        chk("memSel", 32'(EPC_SEL_EXTRA_ROWS_SELECT), memSel);
        wr(8'h80);
        arr(1'b0, 14'h3fff, 8'h00);
        chk("memAddr", 32'h3fff, memAddr);
    endtask
    // Unmapped place is refused with an error and zero data
    task automatic tUnmapped();
        logic [31:0] r;
        logic        e;
        apb(1'b0, 12'h010, 32'h0, r, e);
        chk("slverr", 32'h1, e);
        chk("rdata", 32'h0, r);
    endtask

    // ----------------------------------------------------------------
    // Verdict, main sequence and watchdog
    // ----------------------------------------------------------------
    task automatic conclude();
        if (errTotal == 0 && cmpCount > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge sys_clk);
        resetn <= 1'b1;
        tModes();
        tStress();
        tVoltage();
        tLatch();
        tFold();
        tUnmapped();
        conclude();
    end
    // Whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge sys_clk);
        errTotal++;
        conclude();
    end
endmodule
`default_nettype wire
